// File: src/gia_pkg.sv
// Package of constants and types for the grouped interrupt aggregator.
package gia_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NUM_GROUPS  = 19;
  localparam int FIRST_GROUP = 8;
  localparam int SRC_BITS    = 31;
  localparam int ADDR_W      = 12;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [11:0] GROUP_STRIDE    = 12'h014;
  localparam logic [11:0] OFS_STATUS      = 12'h000;
  localparam logic [11:0] OFS_EN_SET      = 12'h004;
  localparam logic [11:0] OFS_RESULT      = 12'h008;
  localparam logic [11:0] OFS_EN_CLEAR    = 12'h00C;
  localparam logic [11:0] OFS_GROUP_END   = 12'h178;
  localparam logic [11:0] OFS_BLK_EN_SET  = 12'h200;
  localparam logic [11:0] OFS_BLK_EN_CLR  = 12'h204;
  localparam logic [11:0] OFS_BLK_VECTOR  = 12'h208;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int BLK_LSB = 8;
  localparam int BLK_MSB = 26;
  localparam logic [30:0] SRC_RESET = 31'h00000000;
  localparam logic [18:0] BLK_RESET = 19'h00000;
  // Default: every source position implemented.
  localparam logic [30:0] ALL_PRESENT = 31'h7FFFFFFF;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [30:0] gia_src_t;
  typedef logic [18:0] gia_grp_t;

  typedef enum logic [1:0] {
    GIA_KIND_STATUS = 2'h0,
    GIA_KIND_EN_SET = 2'h1,
    GIA_KIND_RESULT = 2'h2,
    GIA_KIND_EN_CLR = 2'h3
  } gia_kind_e;

  typedef struct packed {
    logic        hit;
    logic [4:0]  group;
    gia_kind_e   kind;
  } gia_dec_s;

endpackage : gia_pkg

// File: src/gia_aggregator.sv
// Grouped interrupt aggregator with an APB register slave.
`timescale 1ns/100ps
module gia_aggregator #(
  parameter logic [19*31-1:0] SRC_PRESENT = {19{gia_pkg::ALL_PRESENT}}
) (
  // Clock and reset
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  // APB slave
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [gia_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]              pwdata,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Peripheral events, one-cycle or level, same clock domain
  input  wire logic [19*31-1:0]         event_in,
  // Requests toward the processor vector controller
  output logic      [18:0]              group_irq,
  output logic                          irq
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic gia_pkg::gia_dec_s decode(
    input logic [gia_pkg::ADDR_W-1:0] a);
    gia_pkg::gia_dec_s d;
    logic [11:0] rem;
    d = '{hit: 1'b0, group: 5'h00, kind: gia_pkg::GIA_KIND_STATUS};
    rem = a;
    if (a < gia_pkg::OFS_GROUP_END && a[1:0] == 2'h0) begin
      for (int g = 0; g < gia_pkg::NUM_GROUPS; g++) begin
        if (rem >= gia_pkg::GROUP_STRIDE) begin
          rem = rem - gia_pkg::GROUP_STRIDE;
          d.group = d.group + 5'h01;
        end
      end
      d.hit = (rem < 12'h010);
      d.kind = gia_pkg::gia_kind_e'(rem[3:2]);
    end
    return d;
  endfunction

  gia_pkg::gia_dec_s dec;
  logic              access;
  logic              wr_acc;
  logic              blk_hit;

  assign dec     = decode(paddr);
  assign access  = psel && penable && !pready;
  assign wr_acc  = access && pwrite;
  assign blk_hit = (paddr == gia_pkg::OFS_BLK_EN_SET) ||
                   (paddr == gia_pkg::OFS_BLK_EN_CLR) ||
                   (paddr == gia_pkg::OFS_BLK_VECTOR);

  // ----------------------------------------------------------------
  // Source status and enables
  // ----------------------------------------------------------------
  gia_pkg::gia_src_t status [gia_pkg::NUM_GROUPS];
  gia_pkg::gia_src_t enable [gia_pkg::NUM_GROUPS];
  gia_pkg::gia_src_t result [gia_pkg::NUM_GROUPS];
  gia_pkg::gia_grp_t blk_en;
  gia_pkg::gia_grp_t next_group_irq;

  for (genvar g = 0; g < gia_pkg::NUM_GROUPS; g++) begin : g_grp
    gia_pkg::gia_src_t present;
    gia_pkg::gia_src_t ev;
    gia_pkg::gia_src_t wmask;
    assign present = SRC_PRESENT[g*31 +: 31];
    assign ev      = event_in[g*31 +: 31] & present;
    assign wmask   = pwdata[30:0] & present;
    assign result[g] = status[g] & enable[g];
    assign next_group_irq[g] = blk_en[g] && (|result[g]);

    // Events win over a same-cycle write-one-to-clear.
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        status[g] <= gia_pkg::SRC_RESET;
      end else if (wr_acc && dec.hit && dec.group == 5'(g) &&
                   dec.kind == gia_pkg::GIA_KIND_STATUS) begin
        status[g] <= (status[g] & ~wmask) | ev;
      end else begin
        status[g] <= status[g] | ev;
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        enable[g] <= gia_pkg::SRC_RESET;
      end else if (wr_acc && dec.hit && dec.group == 5'(g)) begin
        if (dec.kind == gia_pkg::GIA_KIND_EN_SET) begin
          enable[g] <= enable[g] | wmask;
        end else if (dec.kind == gia_pkg::GIA_KIND_EN_CLR) begin
          enable[g] <= enable[g] & ~wmask;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Block enables and group requests
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blk_en <= gia_pkg::BLK_RESET;
    end else if (wr_acc && paddr == gia_pkg::OFS_BLK_EN_SET) begin
      blk_en <= blk_en | pwdata[gia_pkg::BLK_MSB:gia_pkg::BLK_LSB];
    end else if (wr_acc && paddr == gia_pkg::OFS_BLK_EN_CLR) begin
      blk_en <= blk_en & ~pwdata[gia_pkg::BLK_MSB:gia_pkg::BLK_LSB];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      group_irq <= gia_pkg::BLK_RESET;
      irq       <= 1'b0;
    end else begin
      group_irq <= next_group_irq;
      irq       <= |next_group_irq;
    end
  end

  // ----------------------------------------------------------------
  // APB read and response
  // ----------------------------------------------------------------
  logic [31:0] next_prdata;

  always_comb begin
    next_prdata = 32'h00000000;
    if (dec.hit) begin
      unique case (dec.kind)
        gia_pkg::GIA_KIND_STATUS: next_prdata = {1'b0, status[dec.group]};
        gia_pkg::GIA_KIND_RESULT: next_prdata = {1'b0, result[dec.group]};
        gia_pkg::GIA_KIND_EN_SET,
        gia_pkg::GIA_KIND_EN_CLR: begin
          next_prdata = {1'b0, enable[dec.group]};
        end
      endcase
    end else if (paddr == gia_pkg::OFS_BLK_EN_SET ||
                 paddr == gia_pkg::OFS_BLK_EN_CLR) begin
      next_prdata = {5'h00, blk_en, 8'h00};
    end else if (paddr == gia_pkg::OFS_BLK_VECTOR) begin
      next_prdata = {5'h00, group_irq, 8'h00};
    end
  end

  // One wait state: pready rises in the second access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= access;
      pslverr <= access && !(dec.hit || blk_hit);
      prdata  <= (access && !pwrite) ? next_prdata : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_result_and;
    @(posedge pclk) disable iff (!presetn)
      (access && !pwrite && dec.hit && dec.group == 5'h00 &&
       dec.kind == gia_pkg::GIA_KIND_RESULT)
      |=> prdata == {1'b0, $past(status[0]) & $past(enable[0])};
  endproperty
  a_result_and: assert property (p_result_and)
    else $error("result mismatch");

  property p_status_sticky;
    @(posedge pclk) disable iff (!presetn)
      (status[0][0] && !(wr_acc && dec.hit && dec.group == 5'h00 &&
       dec.kind == gia_pkg::GIA_KIND_STATUS && pwdata[0]))
      |=> status[0][0];
  endproperty
  a_status_sticky: assert property (p_status_sticky)
    else $error("status lost");

  property p_event_sets;
    @(posedge pclk) disable iff (!presetn)
      (event_in[0] && SRC_PRESENT[0]) |=> status[0][0];
  endproperty
  a_event_sets: assert property (p_event_sets)
    else $error("event missed");

  property p_en_set;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && dec.hit && dec.group == 5'h00 &&
       dec.kind == gia_pkg::GIA_KIND_EN_SET && pwdata[0] && SRC_PRESENT[0])
      |=> enable[0][0];
  endproperty
  a_en_set: assert property (p_en_set)
    else $error("enable not set");

  property p_en_clr;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && dec.hit && dec.group == 5'h00 &&
       dec.kind == gia_pkg::GIA_KIND_EN_CLR && pwdata[0])
      |=> !enable[0][0];
  endproperty
  a_en_clr: assert property (p_en_clr)
    else $error("enable not cleared");

  property p_blk_set;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && paddr == gia_pkg::OFS_BLK_EN_SET && pwdata[8]) |=> blk_en[0];
  endproperty
  a_blk_set: assert property (p_blk_set)
    else $error("block set failed");

  property p_blk_clr;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && paddr == gia_pkg::OFS_BLK_EN_CLR && pwdata[8])
      |=> !blk_en[0];
  endproperty
  a_blk_clr: assert property (p_blk_clr)
    else $error("block clear failed");

  property p_irq_gated;
    @(posedge pclk) disable iff (!presetn)
      !blk_en[0] |=> !group_irq[0];
  endproperty
  a_irq_gated: assert property (p_irq_gated)
    else $error("request leaked");

  property p_irq_follows;
    @(posedge pclk) disable iff (!presetn)
      (blk_en[0] && |result[0]) |=> group_irq[0];
  endproperty
  a_irq_follows: assert property (p_irq_follows)
    else $error("request missing");

  property p_bit31_zero;
    @(posedge pclk) disable iff (!presetn)
      (pready && dec.hit) |-> !prdata[31];
  endproperty
  a_bit31_zero: assert property (p_bit31_zero)
    else $error("bit 31 set");

  property p_enable_read;
    @(posedge pclk) disable iff (!presetn)
      (access && !pwrite && dec.hit && dec.group == 5'h00 &&
       dec.kind == gia_pkg::GIA_KIND_EN_CLR)
      |=> prdata == {1'b0, $past(enable[0])};
  endproperty
  a_enable_read: assert property (p_enable_read)
    else $error("enable read wrong");

  property p_absent_quiet;
    @(posedge pclk) disable iff (!presetn)
      ((status[0] | enable[0]) & ~SRC_PRESENT[30:0]) == 31'h00000000;
  endproperty
  a_absent_quiet: assert property (p_absent_quiet)
    else $error("absent source active");

  property p_en_clr_zero;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && dec.hit && dec.group == 5'h00 &&
       dec.kind == gia_pkg::GIA_KIND_EN_CLR && !pwdata[0])
      |=> enable[0][0] == $past(enable[0][0]);
  endproperty
  a_en_clr_zero: assert property (p_en_clr_zero)
    else $error("enable cleared by zero");

  property p_en_set_zero;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && dec.hit && dec.group == 5'h00 &&
       dec.kind == gia_pkg::GIA_KIND_EN_SET && !pwdata[0])
      |=> enable[0][0] == $past(enable[0][0]);
  endproperty
  a_en_set_zero: assert property (p_en_set_zero)
    else $error("enable set by zero");

  property p_result_wr;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && dec.hit && dec.group == 5'h00 &&
       dec.kind == gia_pkg::GIA_KIND_RESULT) |=> $stable(enable[0]);
  endproperty
  a_result_wr: assert property (p_result_wr)
    else $error("result write had effect");

  property p_vector_read;
    @(posedge pclk) disable iff (!presetn)
      (access && !pwrite && paddr == gia_pkg::OFS_BLK_VECTOR)
      |=> prdata == {5'h00, $past(group_irq), 8'h00};
  endproperty
  a_vector_read: assert property (p_vector_read)
    else $error("vector read wrong");

  property p_last_group;
    @(posedge pclk) disable iff (!presetn)
      (blk_en[18] && |result[18]) |=> group_irq[18] && irq;
  endproperty
  a_last_group: assert property (p_last_group)
    else $error("last group request missing");

  property p_reset_clear;
    @(posedge pclk)
      !presetn |-> (status[0] == gia_pkg::SRC_RESET &&
                    enable[0] == gia_pkg::SRC_RESET &&
                    blk_en == gia_pkg::BLK_RESET && !irq && !pready);
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("state not cleared in reset");

endmodule : gia_aggregator

// File: bench/gia_vector_model.sv
// Model of the processor vector controller fed by the group requests.
`timescale 1ns/100ps
module gia_vector_model (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Requests from the aggregator
  input  wire logic [18:0] group_irq,
  input  wire logic        irq,
  // Acknowledge and observed state
  input  wire logic [18:0] ack,
  output logic      [18:0] pending,
  output logic             irq_bad
);
  // Requests latch as pending until the bench acknowledges them.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending <= '0;
      irq_bad <= 1'b0;
    end else begin
      pending <= (pending & ~ack) | group_irq;
      irq_bad <= irq_bad | (irq != (|group_irq));
    end
  end
endmodule // gia_vector_model

// File: bench/gia_aggregator_tb.sv
// Self-checking testbench for the grouped interrupt aggregator.
`timescale 1ns/100ps
module gia_aggregator_tb;
  // Source 5 of the first group is absent in this variant.
  localparam logic [588:0] PRESENT =
    {19{gia_pkg::ALL_PRESENT}} & ~(589'h1 << 5);
  logic         pclk, presetn, psel, penable, pwrite, pready;
  logic         pslverr, irq, irq_bad, rerr;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rdata;
  logic [588:0] event_in;
  logic [18:0]  group_irq, pending, ack;
  int           num_errors, tests_run;

  gia_aggregator #(.SRC_PRESENT(PRESENT)) dut_u (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .event_in(event_in), .group_irq(group_irq),
    .irq(irq));
  gia_vector_model model_u (.pclk(pclk), .presetn(presetn),
    .group_irq(group_irq), .irq(irq), .ack(ack), .pending(pending),
    .irq_bad(irq_bad));

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer; read data and error are taken at the pready edge.
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdata   = prdata;
    rerr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    chk(rdata, exp);
  endtask

  task automatic ev(input logic [588:0] v);
    @(posedge pclk);
    event_in <= v;
    @(posedge pclk);
    event_in <= '0;
  endtask

  task automatic settle();
    repeat (2) @(posedge pclk);
    #1;
  endtask

  task automatic conclude();
    $display("checks=%0d errors=%0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite} = 4'h0;
    {paddr, pwdata, event_in, ack} = '0;
    num_errors = 0;
    tests_run = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 32'h00000000);
    rd(12'h004, 32'h00000000);
    rd(12'h008, 32'h00000000);
    rd(12'h200, 32'h00000000);
    ev(589'h40000021);
    rd(12'h000, 32'h40000001);
    wr(12'h000, 32'h80000000);
    rd(12'h000, 32'h40000001);
    rd(12'h008, 32'h00000000);
    wr(12'h004, 32'hFFFFFFFF);
    rd(12'h004, 32'h7FFFFFDF);
    rd(12'h00C, 32'h7FFFFFDF);
    rd(12'h008, 32'h40000001);
    wr(12'h008, 32'h00000000);
    rd(12'h008, 32'h40000001);
    settle();
    chk(32'(group_irq), 32'h00000000);
    wr(12'h200, 32'h00000100);
    rd(12'h200, 32'h00000100);
    rd(12'h208, 32'h00000100);
    settle();
    chk(32'({group_irq, irq}), 32'h00000003);
    chk(32'({pending, irq_bad}), 32'h00000002);
    wr(12'h00C, 32'h00000001);
    wr(12'h00C, 32'h00000000);
    wr(12'h004, 32'h00000000);
    rd(12'h004, 32'h7FFFFFDE);
    rd(12'h008, 32'h40000000);
    wr(12'h000, 32'h40000000);
    rd(12'h000, 32'h00000001);
    rd(12'h208, 32'h00000000);
    settle();
    chk(32'(irq), 32'h00000000);
    wr(12'h200, 32'h00000000);
    rd(12'h200, 32'h00000100);
    wr(12'h204, 32'h00000100);
    rd(12'h204, 32'h00000000);
    ev(589'h1 << 558);
    wr(12'h16C, 32'h00000001);
    wr(12'h200, 32'h04000000);
    rd(12'h208, 32'h04000000);
    settle();
    chk(32'(group_irq), 32'h00040000);
    wr(12'h204, 32'h04000000);
    rd(12'h208, 32'h00000000);
    settle();
    chk(32'({group_irq, irq_bad}), 32'h00000000);
    chk(32'(pending), 32'h00040001);
    @(posedge pclk);
    ack <= '1;
    @(posedge pclk);
    ack <= '0;
    settle();
    chk(32'(pending), 32'h00000000);
    apb(1'b0, 12'h010, 32'h00000000);
    chk(rdata, 32'h00000000);
    chk(32'(rerr), 32'h00000001);
    // Reset in mid-run with a source, its enable and a block enable set.
    wr(12'h200, 32'h00000100);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h000, 32'h00000000);
    rd(12'h004, 32'h00000000);
    rd(12'h200, 32'h00000000);
    conclude();
  end

  initial begin
    #(3000 * 50);
    num_errors++;
    conclude();
  end
endmodule // gia_aggregator_tb
